// File: verilog/qp_cfg.svh
// constants for the quad pot command decoder: fields, resets, timing
`ifndef QP_CFG_SVH
`define QP_CFG_SVH

// address byte: type field in the upper nibble, strap pins below
`define QP_TYPE_LSB 4
// type code value is arbitrary, not a real part code
`define QP_TYPE_CODE 4'h6

// instruction byte fields
`define QP_OP_LSB 4
`define QP_SLOT_LSB 2
`define QP_POT_LSB 0

// bits in one byte, counted on the serial clock
`define QP_BYTE_BITS 4'h8

// nonvolatile slot contents after reset, and tap limits
`define QP_BOOT_VALUE 8'h80
`define QP_TAP_MAX 8'hFF
`define QP_TAP_MIN 8'h00

// nonvolatile programming time and the cycles it takes at clk
`define QP_NV_PROG_MS 10
`define QP_CLK_MHZ 250
`define QP_NV_PROG_CYCLES (`QP_NV_PROG_MS * 1000 * `QP_CLK_MHZ)

`endif

// File: verilog/qp_pkg.sv
// types shared by the quad pot command decoder
package qp_pkg;

  typedef logic [7:0] qp_tap_t;
  typedef logic [3:0][7:0] qp_wipers_t;
  // indexed [pot][slot]
  typedef logic [3:0][3:0][7:0] qp_slots_t;

  // instruction opcodes, upper nibble of the instruction byte
  typedef enum logic [3:0] {
    QP_OP_RD_WIPER = 4'h9,
    QP_OP_WR_WIPER = 4'hA,
    QP_OP_RD_SLOT = 4'hB,
    QP_OP_WR_SLOT = 4'hC,
    QP_OP_SLOT2WIPER = 4'hD,
    QP_OP_WIPER2SLOT = 4'hE,
    QP_OP_GANG_S2W = 4'h1,
    QP_OP_GANG_W2S = 4'h8,
    QP_OP_STEP = 4'h2
  } qp_op_e;

  // frame decoder states, one-hot
  typedef enum logic [10:0] {
    QP_ST_IDLE = 11'h001,
    QP_ST_ADDR = 11'h002,
    QP_ST_ADDR_ACK = 11'h004,
    QP_ST_INSTR = 11'h008,
    QP_ST_INSTR_ACK = 11'h010,
    QP_ST_WDATA = 11'h020,
    QP_ST_WDATA_ACK = 11'h040,
    QP_ST_RDATA = 11'h080,
    QP_ST_RDATA_ACK = 11'h100,
    QP_ST_STEP = 11'h200,
    QP_ST_IGNORE = 11'h400
  } qp_state_e;

  // one nonvolatile programming job
  typedef struct packed {
    logic [3:0] mask;
    logic [1:0] slot;
    qp_wipers_t data;
  } qp_nv_req_s;

endpackage

// File: verilog/qp_nv_store.sv
// nonvolatile slot store with its programming delay
`timescale 1ns/10ps
`include "qp_cfg.svh"
module qp_nv_store #(
  parameter int PROG_CYCLES = `QP_NV_PROG_CYCLES,
  parameter logic [7:0] BOOT_VALUE = `QP_BOOT_VALUE
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire qp_pkg::qp_nv_req_s req,
  output logic busy,
  output qp_pkg::qp_slots_t slots
);
  import qp_pkg::*;

  localparam int CW = $clog2(PROG_CYCLES + 1);

  if (PROG_CYCLES < 1) begin : g_chk
    $error("PROG_CYCLES must be at least one");
  end

  logic [CW-1:0] cnt_reg;
  logic busy_reg;
  qp_nv_req_s hold_reg;
  qp_slots_t slot_reg;
  qp_slots_t slot_next;

  ////////////////////////////////////////////////////////////////////////
  // a job starts idle; the decoder never asks while busy
  wire launch = req_valid && !busy_reg;
  wire commit = busy_reg && (cnt_reg == '0);

  // value lands only when the full program time has run out
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      cnt_reg <= '0;
      hold_reg <= '0;
    end else if (launch) begin
      busy_reg <= 1'b1; // R13
      cnt_reg <= CW'(PROG_CYCLES - 1);
      hold_reg <= req;
    end else if (commit) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-slot update from the held job
  for (genvar p = 0; p < 4; p++) begin : g_pot
    for (genvar s = 0; s < 4; s++) begin : g_slot
      assign slot_next[p][s] =
        (commit && hold_reg.mask[p] && hold_reg.slot == 2'(s)) ?
        hold_reg.data[p] : slot_reg[p][s]; // R13
    end
  end

  // flops stand in for the cells; reset loads a plain value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slot_reg <= {16{BOOT_VALUE}};
    end else begin
      slot_reg <= slot_next;
    end
  end

  assign busy = busy_reg;
  assign slots = slot_reg;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_prog_start: assert property (launch |=> busy_reg [*8]) // R13
    else $error("programming did not hold busy");
  a_prog_count: assert property (launch |=> // R13
    cnt_reg == CW'(PROG_CYCLES - 1))
    else $error("program counter not loaded with full time");
  a_prog_land: assert property (commit && hold_reg.mask[0] |=> // R13
    slot_reg[0][$past(hold_reg.slot)] == $past(hold_reg.data[0]))
    else $error("slot not written at end of programming");
  c_prog_done: cover property (commit);
endmodule

// File: verilog/qp_cmd_target.sv
// serial command target for the quad digital potentiometer
//
// Behaviour
// R1 - START, then type nibble and strap nibble; acknowledge only on match
// R2 - opcode 1001 00 pp returns the selected wiper, bit 7 first
// R3 - opcode 1010 00 pp takes one data byte into the selected wiper
// R4 - opcode 1011 ss pp returns the chosen slot, bit 7 first
// R5 - opcode 1100 ss pp takes one data byte into the chosen slot
// R6 - opcode 0001 ss 00 copies slot ss of every pot into its wiper
// R7 - opcode 1000 ss 00 stores every wiper into its slot ss
// R8 - opcode 1110 ss pp stores one wiper into its slot ss
// R9 - opcode 1101 ss pp loads one wiper from its slot ss
// R10 - opcode 0010 00 pp then step bits until STOP
// R11 - slot programming begins only after the closing STOP
// R12 - each clock pulse steps up when data high, down when low
// R13 - a slot change takes up to 10 ms to settle
// R14 - after reset every wiper loads from its boot slot
// R15 - stepping holds at tap 0 and tap 255, no wrap
`timescale 1ns/10ps
`include "qp_cfg.svh"
module qp_cmd_target #(
  parameter int NV_PROG_CYCLES = `QP_NV_PROG_CYCLES,
  parameter logic [3:0] TYPE_CODE = `QP_TYPE_CODE
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [3:0] strap_bits,
  output qp_pkg::qp_wipers_t wiper_position,
  output logic nv_busy
);
  import qp_pkg::*;

  if (NV_PROG_CYCLES < 1) begin : g_chk
    $error("NV_PROG_CYCLES must be at least one");
  end

  qp_state_e state_reg;
  qp_state_e state_next;
  logic scl_q;
  logic sda_q;
  logic boot_reg;
  logic [3:0] strap_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic step_bit_reg;
  qp_op_e op_reg;
  logic [1:0] slot_reg;
  logic [1:0] pot_reg;
  logic sda_oe_reg;
  logic pend_reg;
  qp_nv_req_s pend_req_reg;
  logic nv_req_reg;
  qp_nv_req_s nv_req_data_reg;
  qp_wipers_t wiper_reg;
  qp_wipers_t wiper_next;
  qp_slots_t slots;
  logic busy_w;

  ////////////////////////////////////////////////////////////////////////
  // bus events; inputs are synchronous, one stage gives the history
  wire scl_rise = scl && !scl_q;
  wire scl_fall = !scl && scl_q;
  wire start_det = scl && scl_q && sda_q && !sda_in; // R1
  wire stop_det = scl && scl_q && !sda_q && sda_in;
  wire byte_full = bit_cnt_reg == `QP_BYTE_BITS;

  // fields of the byte just shifted in
  wire [3:0] in_op = shift_reg[`QP_OP_LSB +: 4];
  wire [1:0] in_slot = shift_reg[`QP_SLOT_LSB +: 2];
  wire [1:0] in_pot = shift_reg[`QP_POT_LSB +: 2];
  wire slot_zero = in_slot == 2'h0;
  wire pot_zero = in_pot == 2'h0;

  // a busy store refuses new frames at the address byte
  wire addr_ok = shift_reg[`QP_TYPE_LSB +: 4] == TYPE_CODE &&
                 shift_reg[3:0] == strap_reg && !busy_w; // R1

  // legal instruction bytes, reserved bits checked
  wire op_rd_w = in_op == QP_OP_RD_WIPER && slot_zero; // R2
  wire op_wr_w = in_op == QP_OP_WR_WIPER && slot_zero; // R3
  wire op_step = in_op == QP_OP_STEP && slot_zero; // R10
  wire op_g_s2w = in_op == QP_OP_GANG_S2W && pot_zero; // R6
  wire op_g_w2s = in_op == QP_OP_GANG_W2S && pot_zero; // R7
  wire op_free = in_op == QP_OP_RD_SLOT || in_op == QP_OP_WR_SLOT ||
                 in_op == QP_OP_SLOT2WIPER || in_op == QP_OP_WIPER2SLOT;
  wire instr_ok = op_rd_w || op_wr_w || op_step || op_g_s2w ||
                  op_g_w2s || op_free;

  // completion strobes of the frame bytes
  wire instr_done = scl_fall && state_reg == QP_ST_INSTR && byte_full &&
                    instr_ok;
  wire data_done = scl_fall && state_reg == QP_ST_WDATA && byte_full;
  wire step_edge = scl_fall && state_reg == QP_ST_STEP; // R12
  wire rx_rise = scl_rise && (state_reg == QP_ST_ADDR ||
                 state_reg == QP_ST_INSTR || state_reg == QP_ST_WDATA);
  wire tx_fall = scl_fall && state_reg == QP_ST_RDATA;

  // byte returned by the two read frames
  wire [7:0] rd_byte = (op_reg == QP_OP_RD_WIPER) ?
                       wiper_reg[pot_reg] : // R2
                       slots[pot_reg][slot_reg]; // R4

  ////////////////////////////////////////////////////////////////////////
  // frame sequencing; START and STOP override anything in flight
  always_comb begin
    state_next = state_reg;
    if (start_det) begin
      state_next = QP_ST_ADDR; // R1
    end else if (stop_det) begin
      state_next = QP_ST_IDLE;
    end else if (scl_fall) begin
      case (state_reg)
        QP_ST_ADDR: begin
          if (byte_full) begin
            state_next = addr_ok ? QP_ST_ADDR_ACK : QP_ST_IGNORE; // R1
          end
        end
        QP_ST_ADDR_ACK: state_next = QP_ST_INSTR;
        QP_ST_INSTR: begin
          if (byte_full) begin
            state_next = instr_ok ? QP_ST_INSTR_ACK : QP_ST_IGNORE;
          end
        end
        QP_ST_INSTR_ACK: begin
          case (op_reg)
            QP_OP_RD_WIPER: state_next = QP_ST_RDATA; // R2
            QP_OP_RD_SLOT: state_next = QP_ST_RDATA; // R4
            QP_OP_WR_WIPER: state_next = QP_ST_WDATA; // R3
            QP_OP_WR_SLOT: state_next = QP_ST_WDATA; // R5
            QP_OP_STEP: state_next = QP_ST_STEP; // R10
            default: state_next = QP_ST_IGNORE;
          endcase
        end
        QP_ST_WDATA: begin
          if (byte_full) begin
            state_next = QP_ST_WDATA_ACK;
          end
        end
        QP_ST_WDATA_ACK: state_next = QP_ST_IGNORE;
        QP_ST_RDATA: begin
          if (bit_cnt_reg == 4'h7) begin
            state_next = QP_ST_RDATA_ACK;
          end
        end
        QP_ST_RDATA_ACK: state_next = QP_ST_IGNORE;
        default: state_next = state_reg;
      endcase
    end
  end

  // data line: pull low for acks and for zero read bits only
  wire ack_next = state_next == QP_ST_ADDR_ACK ||
                  state_next == QP_ST_INSTR_ACK ||
                  state_next == QP_ST_WDATA_ACK;
  wire rd_bit = (state_reg == QP_ST_INSTR_ACK) ? rd_byte[7] : tx_reg[6];
  wire drive_next = ack_next ||
                    (state_next == QP_ST_RDATA && !rd_bit); // R2
  wire oe_next = (start_det || stop_det) ? 1'b0 :
                 scl_fall ? drive_next : sda_oe_reg;

  ////////////////////////////////////////////////////////////////////////
  // line history, state and the data driver
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      state_reg <= QP_ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
      state_reg <= state_next;
      sda_oe_reg <= oe_next;
    end
  end

  // straps caught once, just after reset release
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      boot_reg <= 1'b1;
      strap_reg <= 4'h0;
    end else begin
      boot_reg <= 1'b0;
      if (boot_reg) begin
        strap_reg <= strap_bits; // R1
      end
    end
  end

  // bit counting and shifting, msb first both ways
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      step_bit_reg <= 1'b0;
    end else begin
      if (start_det || state_next != state_reg) begin
        bit_cnt_reg <= 4'h0;
      end else if (rx_rise || tx_fall) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      if (rx_rise) begin
        shift_reg <= {shift_reg[6:0], sda_in};
      end
      if (scl_rise) begin
        step_bit_reg <= sda_in; // R12
      end
      if (scl_fall && state_reg == QP_ST_INSTR_ACK) begin
        tx_reg <= rd_byte; // R4
      end else if (tx_fall) begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // instruction fields kept for the rest of the frame
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_reg <= QP_OP_STEP;
      slot_reg <= 2'h0;
      pot_reg <= 2'h0;
    end else if (instr_done) begin
      op_reg <= qp_op_e'(in_op);
      slot_reg <= in_slot;
      pot_reg <= in_pot;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // programming jobs wait for STOP; a repeated START drops them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_reg <= 1'b0;
      pend_req_reg <= '0;
      nv_req_reg <= 1'b0;
      nv_req_data_reg <= '0;
    end else begin
      nv_req_reg <= stop_det && pend_reg; // R11
      if (stop_det) begin
        nv_req_data_reg <= pend_req_reg;
      end
      if (start_det || stop_det) begin
        pend_reg <= 1'b0;
      end else if (data_done && op_reg == QP_OP_WR_SLOT) begin
        pend_reg <= 1'b1; // R5
        pend_req_reg <= '{mask: 4'h1 << pot_reg, slot: slot_reg,
                          data: {4{shift_reg}}};
      end else if (instr_done && in_op == QP_OP_WIPER2SLOT) begin
        pend_reg <= 1'b1; // R8
        pend_req_reg <= '{mask: 4'h1 << in_pot, slot: in_slot,
                          data: wiper_reg};
      end else if (instr_done && op_g_w2s) begin
        pend_reg <= 1'b1; // R7
        pend_req_reg <= '{mask: 4'hF, slot: in_slot, data: wiper_reg};
      end
    end
  end

  qp_nv_store #(
    .PROG_CYCLES(NV_PROG_CYCLES)
  ) u_store (
    .clk(clk),
    .rst_n(rst_n),
    .req_valid(nv_req_reg),
    .req(nv_req_data_reg),
    .busy(busy_w),
    .slots(slots)
  );

  ////////////////////////////////////////////////////////////////////////
  // per-pot wiper next value; one source wins per cycle
  for (genvar p = 0; p < 4; p++) begin : g_wiper
    wire sel = pot_reg == 2'(p);
    wire copy_one = instr_done && in_op == QP_OP_SLOT2WIPER &&
                    in_pot == 2'(p);
    wire at_top = wiper_reg[p] == `QP_TAP_MAX;
    wire at_bot = wiper_reg[p] == `QP_TAP_MIN;
    // datum caught on the rise, applied on the fall: a STOP never steps
    wire [7:0] stepped = step_bit_reg ?
                         (at_top ? wiper_reg[p] : wiper_reg[p] + 8'h01) :
                         (at_bot ? wiper_reg[p] : wiper_reg[p] - 8'h01);
    assign wiper_next[p] =
      boot_reg ? slots[p][0] : // R14
      (copy_one || (instr_done && op_g_s2w)) ?
        slots[p][in_slot] : // R9 R6
      (data_done && op_reg == QP_OP_WR_WIPER && sel) ? shift_reg : // R3
      (step_edge && sel) ? stepped : // R12 R15
      wiper_reg[p];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wiper_reg <= '0;
    end else begin
      wiper_reg <= wiper_next;
    end
  end

  // open-drain: only ever pulls low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
      nv_busy <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      nv_busy <= busy_w;
    end
  end

  assign sda_oe = sda_oe_reg;
  assign wiper_position = wiper_reg;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_addr_nack: assert property (scl_fall && // R1
    state_reg == QP_ST_ADDR && byte_full && shift_reg[3:0] != strap_reg |=>
    !sda_oe_reg && state_reg == QP_ST_IGNORE)
    else $error("acknowledged a foreign strap address");
  a_rd_wiper_msb: assert property (scl_fall && // R2
    state_reg == QP_ST_INSTR_ACK && op_reg == QP_OP_RD_WIPER |=>
    sda_oe_reg == !wiper_reg[pot_reg][7])
    else $error("wiper read did not start with bit 7");
  a_wr_wiper_load: assert property (data_done && // R3
    op_reg == QP_OP_WR_WIPER |=>
    wiper_reg[$past(pot_reg)] == $past(shift_reg))
    else $error("written byte not in wiper");
  a_rd_slot_msb: assert property (scl_fall && // R4
    state_reg == QP_ST_INSTR_ACK && op_reg == QP_OP_RD_SLOT |=>
    sda_oe_reg == !tx_reg[7])
    else $error("slot read did not start with bit 7");
  a_gang_copy: assert property (instr_done && op_g_s2w |=> // R6
    wiper_reg[3] == $past(slots[3][in_slot]) &&
    wiper_reg[0] == $past(slots[0][in_slot]))
    else $error("gang copy missed a wiper");
  a_nv_after_stop: assert property (nv_req_reg |-> // R11
    $past(stop_det) && $past(pend_reg))
    else $error("programming started inside a frame");
  a_w2s_pending: assert property (instr_done && op_g_w2s |=> // R7
    pend_reg && !nv_req_reg && pend_req_reg.mask == 4'hF)
    else $error("gang store not held for STOP");
  a_step_up: assert property (step_edge && step_bit_reg && // R12
    pot_reg == 2'h0 && wiper_reg[0] != `QP_TAP_MAX |=>
    wiper_reg[0] == $past(wiper_reg[0]) + 8'h01)
    else $error("step up did not move one tap");
  a_step_clamp: assert property (step_edge && !step_bit_reg && // R15
    pot_reg == 2'h2 && wiper_reg[2] == `QP_TAP_MIN |=>
    wiper_reg[2] == `QP_TAP_MIN)
    else $error("step down wrapped past tap 0");
  a_boot_load: assert property (boot_reg |=> // R14
    wiper_reg[0] == $past(slots[0][0]) &&
    wiper_reg[3] == $past(slots[3][0]))
    else $error("wiper not loaded from boot slot");

  c_read_frame: cover property (state_reg == QP_ST_RDATA_ACK);
  c_step_frame: cover property (step_edge);
  c_nv_job: cover property (nv_req_reg);
  c_gang_copy: cover property (instr_done && op_g_s2w);
endmodule

// File: dv/qp_i2c_master.sv
// serial bus master model that drives command frames into the target
`timescale 1ns/10ps
module qp_i2c_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // bus idles high; the line has a pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  //////////////////////////////
  // wait n edges, then step off the edge so nothing races the sampling
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // start, also usable as a repeated start from clock low
  task automatic start();
    sda_low = 1'b0;
    tk(2);
    scl = 1'b1;
    tk(4);
    sda_low = 1'b1;
    tk(4);
    scl = 1'b0;
    tk(2);
  endtask
  // stop: data rises while the clock is high
  task automatic stop();
    sda_low = 1'b1;
    tk(2);
    scl = 1'b1;
    tk(4);
    sda_low = 1'b0;
    tk(4);
  endtask
  // data moves only while the clock is low
  task automatic bit_out(input logic b);
    sda_low = ~b;
    tk(2);
    scl = 1'b1;
    tk(4);
    scl = 1'b0;
    tk(2);
  endtask
  // line released, sampled mid-high where the target holds it steady
  task automatic bit_in(output logic b);
    sda_low = 1'b0;
    tk(2);
    scl = 1'b1;
    tk(2);
    b = sda;
    tk(2);
    scl = 1'b0;
    tk(2);
  endtask
  // byte out msb first, ack returned high when the target pulled low
  task automatic send(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) bit_out(v[i]);
    bit_in(ack);
    ack = ~ack;
  endtask
  // byte in msb first, then the master leaves its ack slot high
  task automatic recv(output logic [7:0] v);
    for (int i = 7; i >= 0; i--) bit_in(v[i]);
    bit_out(1'b1);
  endtask
endmodule

// File: dv/testbench.sv
// self-checking bench for the quad pot serial command target
`timescale 1ns/10ps
module testbench;
  import qp_pkg::*;
  localparam int PROG = 200;
  localparam logic [7:0] ADDR = 8'h63;
  logic clk, rst_n, scl, sda_low, sda_out, sda_oe, nv_busy;
  logic [3:0] strap_bits;
  qp_wipers_t wiper_position;
  wire logic sda;
  int bad_count, cmp_count, busy_base;
  int busy_cnt = 0;
  logic [7:0] rd;
  logic [7:0] exp_w [4];
  // open drain: either party pulls low, else the pull-up wins
  assign sda = ~sda_low & ~(sda_oe & ~sda_out);
  qp_cmd_target #(.NV_PROG_CYCLES(PROG), .TYPE_CODE(4'h6)) u_dut (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .strap_bits(strap_bits),
    .wiper_position(wiper_position), .nv_busy(nv_busy));
  qp_i2c_master u_mst (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  //////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // running total of busy cycles; each job is measured from busy_base
  always @(posedge clk) if (nv_busy === 1'b1) busy_cnt <= busy_cnt + 1;
  task automatic chk(input logic [7:0] g, input logic [7:0] e, string m);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // kind 0 two-byte, 1 write, 2 read; nb step bits taken lsb first from wd
  task automatic frame(input logic [7:0] ins, input int kind,
                       input logic [7:0] wd, input int nb,
                       output logic [7:0] r);
    logic a;
    r = 8'h00;
    u_mst.start();
    u_mst.send(ADDR, a);
    chk({7'h00, a}, 8'h01, "address ack");
    u_mst.send(ins, a);
    chk({7'h00, a}, 8'h01, "instruction ack");
    if (kind == 1) begin
      u_mst.send(wd, a);
      chk({7'h00, a}, 8'h01, "data ack");
    end
    if (kind == 2) u_mst.recv(r);
    for (int i = 0; i < nb; i++) u_mst.bit_out(wd[i]);
    chk({7'h00, nv_busy}, 8'h00, "programming before stop");
    u_mst.stop();
    u_mst.tk(2);
  endtask
  // a frame that must go unacknowledged somewhere
  task automatic refuse(input logic [7:0] a, input logic [7:0] ins);
    logic k;
    u_mst.start();
    u_mst.send(a, k);
    if (k === 1'b1) u_mst.send(ins, k);
    chk({7'h00, k}, 8'h00, "refused frame acked");
    u_mst.stop();
    u_mst.tk(2);
  endtask
  // job must run its full programming time and then finish
  task automatic nv_done();
    int n;
    repeat (PROG + 40) u_mst.tk(1);
    n = busy_cnt - busy_base;
    chk({7'h00, n inside {[PROG:PROG + 1]}}, 8'h01, "prog time");
    chk({7'h00, nv_busy}, 8'h00, "still busy");
    busy_base = busy_cnt;
  endtask
  //////////////////////////////
  initial begin
    #200000;
    bad_count++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    strap_bits = 4'h3;
    bad_count = 0;
    cmp_count = 0;
    busy_base = 0;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    u_mst.tk(4);
    for (int p = 0; p < 4; p++) chk(wiper_position[p], 8'h80, "boot");
    refuse(8'h65, 8'h90);
    refuse(8'h73, 8'h90);
    refuse(ADDR, 8'h30);
    refuse(ADDR, 8'h11);
    refuse(ADDR, 8'h94);
    // every wiper written, then read back
    for (int p = 0; p < 4; p++) begin
      exp_w[p] = 8'h5A ^ (8'h11 << p);
      frame(8'hA0 | 8'(p), 1, exp_w[p], 0, rd);
      chk(wiper_position[p], exp_w[p], "wiper write");
      frame(8'h90 | 8'(p), 2, 8'h00, 0, rd);
      chk(rd, exp_w[p], "wiper read");
    end
    // slot write; target refuses new frames while programming
    frame(8'hCB, 1, 8'h3C, 0, rd);
    refuse(ADDR, 8'h93);
    nv_done();
    frame(8'hBB, 2, 8'h00, 0, rd);
    chk(rd, 8'h3C, "slot read");
    frame(8'hDB, 0, 8'h00, 0, rd);
    exp_w[3] = 8'h3C;
    chk(wiper_position[3], 8'h3C, "slot to wiper");
    frame(8'hE5, 0, 8'h00, 0, rd);
    nv_done();
    frame(8'hB5, 2, 8'h00, 0, rd);
    chk(rd, exp_w[1], "wiper to slot");
    // gang store, clobber wipers, gang recall
    frame(8'h8C, 0, 8'h00, 0, rd);
    nv_done();
    for (int p = 0; p < 4; p++) frame(8'hA0 | 8'(p), 1, 8'h00, 0, rd);
    frame(8'h1C, 0, 8'h00, 0, rd);
    for (int p = 0; p < 4; p++) begin
      chk(wiper_position[p], exp_w[p], "gang");
    end
    // stepping up into the top end, then down; a STOP pulse must not step
    frame(8'hA0, 1, 8'hFE, 0, rd);
    frame(8'h20, 3, 8'h07, 3, rd);
    chk(wiper_position[0], 8'hFF, "step top");
    frame(8'h20, 3, 8'h01, 3, rd);
    chk(wiper_position[0], 8'hFD, "step mixed");
    frame(8'hA2, 1, 8'h01, 0, rd);
    frame(8'h22, 3, 8'h00, 3, rd);
    chk(wiper_position[2], 8'h00, "step bottom");
    chk(wiper_position[1], exp_w[1], "other pot moved");
    final_report();
  end
endmodule
